// ===== src/frar_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// FIFO reset sequencing and serial address register access
// ============================================================
// Behaviour
// - Both FIFOs cleared at power-up automatically
// - Transmit FIFO drains while read enabled, not paused and not empty
// - Reset qualifies after eight consecutive reset-match cycles
// - Disruption before eight ends sequence, no reset
// - Flags stay driven during reset-match
// - Transmit enable holds off transmit counter
// - Counted transmit reset forces full flags
// - Reset-full blocks writes; normal full takes eight
// - Transmit reset proceeds after host removes condition
// - Request release keeps flags; match release floats
// - Transmit completion shown by empty flags
// - Transmit selection ignored cycle after release
// - Tied match: transmit enable stops counter
// - Receive reset progresses after request goes high
// - Receive reset forces empty until new data
// - Receive selection ignored cycle after release
// - Register reached with reset-match; direction pin
// - Address width follows character width
// - Write with special low sets multicast
// - Write with special high sets unicast
// - Register accesses stop receive reset count
// - Continuous selection blocks resets and writes
// - Transmit reset-match when match and request low
// - No match: flag drivers float
module frar_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic addr_match_n,
  input wire logic tx_reset_req_n,
  input wire logic rx_reset_req_n,
  input wire logic tx_select_n,
  input wire logic rx_select_n,
  input wire logic tx_pause_n,
  input wire logic cascade_timing,
  input wire logic char_width_sel,
  input wire logic rx_dir_sel,
  input wire logic rx_special_char_sel,
  input wire logic [frar_pkg::ADDR_W-1:0] rx_char_bus_i,
  output logic [frar_pkg::ADDR_W-1:0] rx_char_bus_o,
  output logic rx_char_bus_oe_n,
  input wire logic tx_host_write,
  input wire logic tx_read_en,
  input wire logic tx_fifo_empty,
  input wire logic tx_fifo_half,
  input wire logic tx_fifo_full,
  input wire logic rx_fifo_empty,
  input wire logic rx_fifo_full,
  input wire logic rx_fifo_write,
  input wire logic [frar_pkg::ADDR_W-1:0] rx_fifo_data,
  input wire logic [frar_pkg::ADDR_W-1:0] rx_addr_char,
  input wire logic rx_addr_valid,
  output logic tx_empty_flag_n,
  output logic tx_half_flag_n,
  output logic tx_full_flag_n,
  output logic tx_flag_oe_n,
  output logic rx_empty_flag_n,
  output logic rx_full_flag_n,
  output logic rx_flag_oe_n,
  output logic tx_fifo_push,
  output logic rx_fifo_pop,
  output logic tx_drain_en,
  output logic tx_fifo_clear,
  output logic rx_fifo_clear,
  output logic addr_hit
);
  import frar_pkg::*;

  // ==========================================================
  // Helper functions
  // ==========================================================

  // Active bits of a character for the chosen width
  function automatic logic [ADDR_W-1:0] width_mask(input logic narrow);
    width_mask = narrow ? MASK_NARROW : MASK_WIDE;
  endfunction : width_mask

  // Address compare in unicast or multicast mode
  function automatic logic addr_cmp(input logic [ADDR_W-1:0] stored,
                                    input logic [ADDR_W-1:0] incoming,
                                    input logic [ADDR_W-1:0] mask,
                                    input frar_mode_t mode);
    logic [ADDR_W-1:0] same;
    same = ~(stored ^ incoming) & mask;
    if (mode == FRAR_UNICAST) begin
      addr_cmp = (same == mask);
    end else begin
      addr_cmp = |same;
    end
  endfunction : addr_cmp

  // ==========================================================
  // Declarations
  // ==========================================================
  frar_top_st_t q, d;
  logic tx_pend; // Transmit reset recognised
  logic rx_pend; // Receive reset recognised
  logic tx_block; // Transmit selection blocked
  logic rx_block; // Receive selection blocked
  logic tx_inhibit; // Transmit enable seen asserted
  logic rx_strobe; // Falling edge of receive select
  logic tx_strobe; // Falling edge of transmit select
  logic [ADDR_W-1:0] mask; // Current width mask

  // Enable polarity that counts as asserted differs in cascade
  // timing, so the hold-off follows the strap
  assign tx_inhibit = cascade_timing ? tx_select_n
                                     : !tx_select_n;
  // Edge detect needs a high-to-low step, so a select held low
  // since reset never strobes
  assign tx_strobe = q.tx_sel_prev && !tx_select_n;
  assign rx_strobe = q.rx_sel_prev && !rx_select_n;
  assign mask = width_mask(char_width_sel);

  // ==========================================================
  // Reset sequencers
  // ==========================================================

  // Transmit side releases when the reset-match goes away
  frar_seq u_tx_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .hit(q.tx_hit),
    .inhibit(tx_inhibit),
    .rel(!q.tx_hit),
    .pend(tx_pend),
    .clear(tx_fifo_clear),
    .block(tx_block)
  );

  // Receive side releases only on a high request; strobes for
  // register access count as disruption
  frar_seq u_rx_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .hit(q.rx_hit),
    .inhibit(!rx_select_n),
    .rel(rx_reset_req_n),
    .pend(rx_pend),
    .clear(rx_fifo_clear),
    .block(rx_block)
  );

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    d = q;
    // Match conditions sampled at each edge
    d.tx_hit = !addr_match_n && !tx_reset_req_n;
    d.tx_match = !addr_match_n && tx_reset_req_n;
    d.rx_hit = !addr_match_n && !rx_reset_req_n;
    d.rx_match = !addr_match_n && rx_reset_req_n;
    d.tx_sel_prev = tx_select_n;
    d.rx_sel_prev = rx_select_n;
    d.tx_push = 1'b0;
    d.rx_pop = 1'b0;

    // Transmit selection; an attempt in the blocked cycle is lost
    // and the next edge needs a fresh deassert first
    if (tx_select_n) begin
      d.tx_selected = 1'b0;
    end else if (tx_strobe && q.tx_match && !tx_block) begin
      d.tx_selected = 1'b1;
    end

    // Writes after a normal full are still counted in
    if (!tx_fifo_full) begin
      d.extra = SEQ_ZERO;
    end
    if (q.tx_selected && tx_host_write && !tx_pend &&
        (!tx_fifo_full || q.extra < EXTRA_WRITES)) begin
      d.tx_push = 1'b1;
      if (tx_fifo_full) begin
        d.extra = q.extra + SEQ_ONE;
      end
    end

    // Drain to the link while reading is enabled, not paused and the FIFO is not empty
    d.drain = tx_read_en && tx_pause_n && !tx_fifo_empty;

    // Transmit flags: forced full while the reset is pending,
    // true FIFO state afterwards shows completion as empty
    if (tx_pend) begin
      d.tx_empty_n = 1'b1;
      d.tx_half_n = 1'b0;
      d.tx_full_n = 1'b0;
    end else begin
      d.tx_empty_n = !tx_fifo_empty;
      d.tx_half_n = !tx_fifo_half;
      d.tx_full_n = !tx_fifo_full;
    end
    d.tx_flag_oe_n = !(d.tx_hit || d.tx_match);

    // Receive flags stay empty from recognition until new data
    if (rx_pend) begin
      d.rx_force = 1'b1;
    end else if (rx_fifo_write) begin
      d.rx_force = 1'b0;
    end
    d.rx_empty_n = !(d.rx_force || rx_fifo_empty);
    d.rx_full_n = d.rx_force || !rx_fifo_full;
    d.rx_flag_oe_n = !(d.rx_hit || d.rx_match);

    // Receive selection and register access
    if (rx_select_n) begin
      d.rx_selected = 1'b0;
      d.reg_rd = 1'b0;
    end else if (rx_strobe && q.rx_hit) begin
      if (rx_dir_sel) begin
        d.reg_rd = 1'b1;
      end else begin
        d.addr = rx_char_bus_i & mask;
        d.mode = rx_special_char_sel ? FRAR_UNICAST
                                     : FRAR_MULTICAST;
      end
    end else if (rx_strobe && q.rx_match && !rx_block) begin
      d.rx_selected = 1'b1;
    end
    if (d.rx_selected && !rx_fifo_empty && !d.rx_force) begin
      d.rx_pop = 1'b1;
    end

    // Bus drive: register value on a read, FIFO data if selected
    if (d.reg_rd) begin
      d.bus_o = q.addr & mask;
      d.bus_oe_n = 1'b0;
    end else if (d.rx_selected) begin
      d.bus_o = rx_fifo_data & mask;
      d.bus_oe_n = 1'b0;
    end else begin
      d.bus_o = ADDR_RESET;
      d.bus_oe_n = 1'b1;
    end

    // Compare incoming address characters
    if (rx_addr_valid) begin
      d.addr_hit = addr_cmp(q.addr, rx_addr_char, mask, q.mode);
    end else begin
      d.addr_hit = 1'b0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Select history resets to asserted so continuous selection
  // from power-up produces no strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '{tx_hit: 1'b0, tx_match: 1'b0, rx_hit: 1'b0,
             rx_match: 1'b0, tx_sel_prev: 1'b0, rx_sel_prev: 1'b0,
             tx_selected: 1'b0, rx_selected: 1'b0, reg_rd: 1'b0,
             extra: SEQ_ZERO, addr: ADDR_RESET, mode: FRAR_MULTICAST,
             rx_force: 1'b0, tx_push: 1'b0, rx_pop: 1'b0,
             drain: 1'b0, tx_empty_n: 1'b1, tx_half_n: 1'b1,
             tx_full_n: 1'b1, tx_flag_oe_n: 1'b1, rx_empty_n: 1'b1,
             rx_full_n: 1'b1, rx_flag_oe_n: 1'b1, bus_o: ADDR_RESET,
             bus_oe_n: 1'b1, addr_hit: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  // ==========================================================
  assign rx_char_bus_o = q.bus_o;
  assign rx_char_bus_oe_n = q.bus_oe_n;
  assign tx_empty_flag_n = q.tx_empty_n;
  assign tx_half_flag_n = q.tx_half_n;
  assign tx_full_flag_n = q.tx_full_n;
  assign tx_flag_oe_n = q.tx_flag_oe_n;
  assign rx_empty_flag_n = q.rx_empty_n;
  assign rx_full_flag_n = q.rx_full_n;
  assign rx_flag_oe_n = q.rx_flag_oe_n;
  assign tx_fifo_push = q.tx_push;
  assign rx_fifo_pop = q.rx_pop;
  assign tx_drain_en = q.drain;
  assign addr_hit = q.addr_hit;

endmodule : frar_top
`default_nettype wire

// ===== inc/frar_pkg.sv
// ============================================================
// Shared constants and state types for the FIFO reset block
// ============================================================
package frar_pkg;

  // Consecutive reset-match cycles that qualify a FIFO reset
  localparam int unsigned SEQ_LEN = 8;
  localparam int unsigned SEQ_CW = 4;
  localparam logic [SEQ_CW-1:0] SEQ_LAST = SEQ_CW'(SEQ_LEN - 1);
  localparam logic [SEQ_CW-1:0] SEQ_ZERO = 4'h0;
  localparam logic [SEQ_CW-1:0] SEQ_ONE = 4'h1;

  // Writes still taken after a normal full first asserts
  localparam logic [SEQ_CW-1:0] EXTRA_WRITES = 4'h8;

  // Address register and character widths
  localparam int unsigned ADDR_W = 10;
  localparam logic [ADDR_W-1:0] MASK_NARROW = 10'h0FF;
  localparam logic [ADDR_W-1:0] MASK_WIDE = 10'h3FF;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;

  // Match mode of the address register
  typedef enum logic {
    FRAR_MULTICAST = 1'b0,
    FRAR_UNICAST = 1'b1
  } frar_mode_t;

  // State of one reset qualification sequencer
  typedef struct packed {
    logic [SEQ_CW-1:0] cnt; // Consecutive reset-match cycles
    logic pend;             // Qualified, waiting for release
    logic release_p;        // One-cycle FIFO clear pulse
    logic block;            // Selection blocked this cycle
  } frar_seq_st_t;

  // State of the top level
  typedef struct packed {
    logic tx_hit;                 // Transmit reset-match
    logic tx_match;               // Transmit normal match
    logic rx_hit;                 // Receive reset-match
    logic rx_match;               // Receive normal match
    logic tx_sel_prev;            // Last sampled transmit select
    logic rx_sel_prev;            // Last sampled receive select
    logic tx_selected;            // Transmit FIFO selected
    logic rx_selected;            // Receive FIFO selected
    logic reg_rd;                 // Address register read active
    logic [SEQ_CW-1:0] extra;     // Writes taken since full
    logic [ADDR_W-1:0] addr;      // Serial address match value
    frar_mode_t mode;             // Unicast or multicast
    logic rx_force;               // Receive flags forced empty
    logic tx_push;                // Write into transmit FIFO
    logic rx_pop;                 // Read from receive FIFO
    logic drain;                  // Transmit FIFO drains to link
    logic tx_empty_n;
    logic tx_half_n;
    logic tx_full_n;
    logic tx_flag_oe_n;
    logic rx_empty_n;
    logic rx_full_n;
    logic rx_flag_oe_n;
    logic [ADDR_W-1:0] bus_o;     // Receive bus drive value
    logic bus_oe_n;               // Receive bus drive enable
    logic addr_hit;               // Incoming address matched
  } frar_top_st_t;

endpackage : frar_pkg

// ===== src/frar_seq.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Reset qualification sequencer for one FIFO side
// ============================================================
module frar_seq (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hit,       // Reset-match present
  input wire logic inhibit,   // Enable asserted, restarts counter
  input wire logic rel,       // External reset condition removed
  output logic pend,          // Reset recognised, not released
  output logic clear,         // One-cycle FIFO clear pulse
  output logic block          // Selection ignored this cycle
);
  import frar_pkg::*;

  frar_seq_st_t q, d;

  // Next-state logic
  always_comb begin
    d = q;
    d.release_p = 1'b0;
    d.block = q.release_p; // Cycle after release blocks selection
    if (q.pend) begin
      // Internal reset waits for the host to remove the reset condition
      d.cnt = SEQ_ZERO;
      if (rel) begin
        d.pend = 1'b0;
        d.release_p = 1'b1;
      end
    end else if (!hit || inhibit) begin
      // Any disruption restarts the count from zero
      d.cnt = SEQ_ZERO;
    end else if (q.cnt == SEQ_LAST) begin
      d.pend = 1'b1;
      d.cnt = SEQ_ZERO;
    end else begin
      d.cnt = q.cnt + SEQ_ONE;
    end
  end

  // State register; clear pulse is high out of reset so both
  // FIFOs are emptied at power-up with no host action
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '{cnt: SEQ_ZERO, pend: 1'b0, release_p: 1'b1, block: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pend = q.pend;
  assign clear = q.release_p;
  assign block = q.block;

endmodule : frar_seq
`default_nettype wire

// ===== dv/frar_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port-level checker for the FIFO reset block
// ============================================================
module frar_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic addr_match_n,
  input wire logic tx_reset_req_n,
  input wire logic rx_reset_req_n,
  input wire logic tx_select_n,
  input wire logic rx_select_n,
  input wire logic rx_dir_sel,
  input wire logic char_width_sel,
  input wire logic tx_fifo_full,
  input wire logic [frar_pkg::ADDR_W-1:0] rx_char_bus_o,
  input wire logic rx_char_bus_oe_n,
  input wire logic tx_full_flag_n,
  input wire logic tx_flag_oe_n,
  input wire logic rx_flag_oe_n,
  input wire logic tx_fifo_push,
  input wire logic tx_fifo_clear,
  input wire logic rx_fifo_clear
);
  import frar_pkg::*;
  // One clock domain, so one default clock and disable
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Reset itself must be visible, so these ignore the disable
  reset_clear_a: assert property (
    disable iff (1'b0) rst |-> tx_fifo_clear && rx_fifo_clear)
    else $error("clears low in reset");
  reset_float_a: assert property (
    disable iff (1'b0)
    rst |-> tx_flag_oe_n && rx_flag_oe_n && rx_char_bus_oe_n)
    else $error("drivers on in reset");
  // Flag drivers follow the address match sampled one edge earlier
  tx_flag_oe_a: assert property (
    !$past(rst) |-> tx_flag_oe_n == $past(addr_match_n))
    else $error("tx flag drive wrong");
  rx_flag_oe_a: assert property (
    !$past(rst) |-> rx_flag_oe_n == $past(addr_match_n))
    else $error("rx flag drive wrong");
  // A forced full needs a reset-match held long before it
  full_forced_a: assert property (
    $fell(tx_full_flag_n) && !tx_fifo_full |->
    !$past(addr_match_n, 8) && !$past(tx_reset_req_n, 8))
    else $error("full forced early");
  tx_release_a: assert property (
    $rose(tx_fifo_clear) |->
    $past(tx_reset_req_n, 2) || $past(addr_match_n, 2))
    else $error("tx clear before release");
  // Receive release acts on the request sampled high at that edge
  rx_release_a: assert property (
    $rose(rx_fifo_clear) |-> $past(rx_reset_req_n))
    else $error("rx clear before release");
  clear_pulse_a: assert property (
    $rose(tx_fifo_clear) |=> !tx_fifo_clear)
    else $error("tx clear too long");
  // A select asserted in the blocked cycle must take no writes for the next three cycles
  sel_block_a: assert property (
    tx_fifo_clear ##1 $fell(tx_select_n) |=> !tx_fifo_push [*3])
    else $error("blocked select wrote");
  read_dir_a: assert property (
    $fell(rx_char_bus_oe_n) |-> $past(rx_dir_sel) && !$past(rx_select_n))
    else $error("bus driven on write");
  read_stop_a: assert property (
    $rose(rx_select_n) |-> ##[1:3] rx_char_bus_oe_n)
    else $error("bus still driven");
  narrow_bus_a: assert property (
    !rx_char_bus_oe_n && char_width_sel |-> rx_char_bus_o[9:8] == 2'h0)
    else $error("narrow read too wide");
endmodule : frar_chk

bind frar_top frar_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .addr_match_n(addr_match_n), .tx_reset_req_n(tx_reset_req_n),
  .rx_reset_req_n(rx_reset_req_n), .tx_select_n(tx_select_n),
  .rx_select_n(rx_select_n), .rx_dir_sel(rx_dir_sel),
  .char_width_sel(char_width_sel), .tx_fifo_full(tx_fifo_full),
  .rx_char_bus_o(rx_char_bus_o), .rx_char_bus_oe_n(rx_char_bus_oe_n),
  .tx_full_flag_n(tx_full_flag_n), .tx_flag_oe_n(tx_flag_oe_n),
  .rx_flag_oe_n(rx_flag_oe_n), .tx_fifo_push(tx_fifo_push),
  .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear));
`default_nettype wire

// ===== dv/frar_fifo_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Behavioural FIFO cores whose status feeds the block
// ============================================================
module frar_fifo_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tx_fifo_push,
  input wire logic tx_fifo_clear,
  input wire logic rx_fifo_clear,
  input wire logic rx_fifo_write,
  input wire logic rx_fifo_pop,
  output logic tx_fifo_empty,
  output logic tx_fifo_half,
  output logic tx_fifo_full,
  output logic rx_fifo_empty,
  output logic rx_fifo_full
);
  logic [3:0] tx_cnt_q; // Transmit occupancy, full at eight, holds at 15
  logic [3:0] rx_cnt_q; // Receive occupancy
  // Occupancy only; contents do not matter to this block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_cnt_q <= 4'h0;
      rx_cnt_q <= 4'h0;
    end else begin
      // Clear wins over a push in the same cycle
      if (tx_fifo_clear) begin
        tx_cnt_q <= 4'h0;
      end else if (tx_fifo_push && tx_cnt_q != 4'hF) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
      if (rx_fifo_clear) begin
        rx_cnt_q <= 4'h0;
      end else if (rx_fifo_write) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
      end else if (rx_fifo_pop && rx_cnt_q != 4'h0) begin
        rx_cnt_q <= rx_cnt_q - 4'h1;
      end
    end
  end
  assign tx_fifo_empty = (tx_cnt_q == 4'h0);
  assign tx_fifo_half = (tx_cnt_q >= 4'h4);
  assign tx_fifo_full = (tx_cnt_q >= 4'h8);
  assign rx_fifo_empty = (rx_cnt_q == 4'h0);
  assign rx_fifo_full = (rx_cnt_q >= 4'h8);
endmodule : frar_fifo_model
`default_nettype wire

// ===== dv/tb_fifo_reset_and_addr_reg_access.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the FIFO reset block
// ============================================================
module tb_fifo_reset_and_addr_reg_access;
  import frar_pkg::*;
  typedef struct {logic w8; logic sc; logic [9:0] d; logic [9:0] in;
    logic [9:0] rd; logic hit;} frar_row_t;
  logic sys_clk, rst, addr_match_n, tx_reset_req_n, rx_reset_req_n;
  logic tx_select_n, rx_select_n, char_width_sel, rx_dir_sel;
  logic rx_special_char_sel, tx_host_write, rx_fifo_write, rx_addr_valid;
  logic [9:0] rx_char_bus_i, rx_char_bus_o, rx_addr_char, rd;
  logic rx_char_bus_oe_n, tx_fifo_empty, tx_fifo_half, tx_fifo_full;
  logic rx_fifo_empty, rx_fifo_full, tx_empty_flag_n, tx_half_flag_n;
  logic tx_full_flag_n, tx_flag_oe_n, rx_empty_flag_n, rx_full_flag_n;
  logic rx_flag_oe_n, tx_fifo_push, rx_fifo_pop, tx_drain_en;
  logic tx_fifo_clear, rx_fifo_clear, addr_hit, tx_clr_seen, rx_clr_seen;
  int num_errors = 0;
  int num_checks = 0;
  // Match-mode cases: unicast exact, multicast any-bit, narrow mask
  frar_row_t rows [5] = '{'{0, 1, 10'h2A5, 10'h2A5, 10'h2A5, 1},
    '{0, 1, 10'h2A5, 10'h2A4, 10'h2A5, 0},
    '{0, 0, 10'h2A5, 10'h15B, 10'h2A5, 1},
    '{0, 0, 10'h2A5, 10'h15A, 10'h2A5, 0},
    '{1, 1, 10'h3C3, 10'h0C3, 10'h0C3, 1}};

  frar_top u_dut (.sys_clk(sys_clk), .rst(rst), .addr_match_n(addr_match_n),
    .tx_reset_req_n(tx_reset_req_n), .rx_reset_req_n(rx_reset_req_n),
    .tx_select_n(tx_select_n), .rx_select_n(rx_select_n), .tx_pause_n(1'b1),
    .cascade_timing(1'b0), .char_width_sel(char_width_sel),
    .rx_dir_sel(rx_dir_sel), .rx_special_char_sel(rx_special_char_sel),
    .rx_char_bus_i(rx_char_bus_i), .rx_char_bus_o(rx_char_bus_o),
    .rx_char_bus_oe_n(rx_char_bus_oe_n), .tx_host_write(tx_host_write),
    .tx_read_en(1'b1), .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_half(tx_fifo_half), .tx_fifo_full(tx_fifo_full),
    .rx_fifo_empty(rx_fifo_empty), .rx_fifo_full(rx_fifo_full),
    .rx_fifo_write(rx_fifo_write), .rx_fifo_data(10'h000),
    .rx_addr_char(rx_addr_char), .rx_addr_valid(rx_addr_valid),
    .tx_empty_flag_n(tx_empty_flag_n), .tx_half_flag_n(tx_half_flag_n),
    .tx_full_flag_n(tx_full_flag_n), .tx_flag_oe_n(tx_flag_oe_n),
    .rx_empty_flag_n(rx_empty_flag_n), .rx_full_flag_n(rx_full_flag_n),
    .rx_flag_oe_n(rx_flag_oe_n), .tx_fifo_push(tx_fifo_push),
    .rx_fifo_pop(rx_fifo_pop), .tx_drain_en(tx_drain_en),
    .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear),
    .addr_hit(addr_hit));
  frar_fifo_model u_fifo (.sys_clk(sys_clk), .rst(rst),
    .tx_fifo_push(tx_fifo_push), .tx_fifo_clear(tx_fifo_clear),
    .rx_fifo_clear(rx_fifo_clear), .rx_fifo_write(rx_fifo_write),
    .rx_fifo_pop(rx_fifo_pop), .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_half(tx_fifo_half), .tx_fifo_full(tx_fifo_full),
    .rx_fifo_empty(rx_fifo_empty), .rx_fifo_full(rx_fifo_full));

  // ============================================================
  // Clock, sticky clear monitors and shared tasks
  // ============================================================
  always #12.5 sys_clk = ~sys_clk;
  // Sticky, so a one-cycle clear pulse is never missed
  always @(posedge sys_clk) begin
    if (tx_fifo_clear === 1'b1) tx_clr_seen <= 1'b1;
    if (rx_fifo_clear === 1'b1) rx_clr_seen <= 1'b1;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task check(input string name, input logic [9:0] seen,
             input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task stop_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // Bounded wait; running out counts as a mismatch
  task wait_on(input int sel);
    logic now_ok;
    for (int n = 0; n < 40; n++) begin
      case (sel)
        0: now_ok = (tx_full_flag_n === 1'b0);
        1: now_ok = (tx_fifo_clear === 1'b1);
        2: now_ok = (rx_fifo_clear === 1'b1);
        default: now_ok = (rx_char_bus_oe_n === 1'b0);
      endcase
      if (now_ok) return;
      tick(1);
    end
    check("wait", 10'h000, 10'h001);
    stop_test();
  endtask : wait_on
  // One register access; strobe held until the read drive shows on a read, two cycles on a write
  task reg_acc(input logic dir, input logic sc, input logic [9:0] d);
    addr_match_n = 0;
    rx_reset_req_n = 0;
    tick(2);
    rx_dir_sel = dir;
    rx_special_char_sel = sc;
    rx_char_bus_i = d;
    rx_select_n = 0;
    if (dir) wait_on(3);
    else tick(2);
    rd = rx_char_bus_o;
    rx_select_n = 1;
    tick(3);
    addr_match_n = 1;
    rx_reset_req_n = 1;
    tick(2);
  endtask : reg_acc

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    {sys_clk, rx_fifo_write, rx_addr_valid, tx_host_write} = 4'h0;
    {rst, addr_match_n, tx_reset_req_n, rx_reset_req_n} = 4'hF;
    {tx_select_n, rx_select_n, char_width_sel, rx_dir_sel} = 4'hC;
    {rx_special_char_sel, tx_clr_seen, rx_clr_seen} = 3'h0;
    rx_char_bus_i = 10'h000;
    rx_addr_char = 10'h000;
    repeat (3) @(posedge sys_clk);
    #1;
    check("tx_fifo_clear", tx_fifo_clear, 1);
    check("rx_fifo_clear", rx_fifo_clear, 1);
    rst = 0;
    tick(2);
    check("tx_flag_oe_n", tx_flag_oe_n, 1);
    {tx_clr_seen, rx_clr_seen} = 2'h0;
    // Write then read back, then offer an incoming address
    foreach (rows[i]) begin
      char_width_sel = rows[i].w8;
      reg_acc(0, rows[i].sc, rows[i].d);
      reg_acc(1, 0, 10'h000);
      check("addr_read", rd, rows[i].rd);
      rx_addr_char = rows[i].in;
      rx_addr_valid = 1;
      tick(1);
      check("addr_hit", addr_hit, rows[i].hit);
      rx_addr_valid = 0;
    end
    check("rx_clr_seen", rx_clr_seen, 0);
    // Request dropped after six cycles: no reset
    addr_match_n = 0;
    tx_reset_req_n = 0;
    tick(6);
    tx_reset_req_n = 1;
    tick(2);
    addr_match_n = 1;
    tick(12);
    check("tx_clr_seen", tx_clr_seen, 0);
    // Enable held during the reset-match holds the count off
    tx_select_n = 0;
    addr_match_n = 0;
    tx_reset_req_n = 0;
    tick(14);
    check("tx_full_flag_n", tx_full_flag_n, 1);
    tx_reset_req_n = 1;
    tick(2);
    {addr_match_n, tx_select_n} = 2'h3;
    tick(2);
    check("tx_clr_seen", tx_clr_seen, 0);
    // Full reset sequence, released by the request
    addr_match_n = 0;
    tx_reset_req_n = 0;
    wait_on(0);
    tick(1);
    check("tx_flags",
      {tx_empty_flag_n, tx_half_flag_n, tx_full_flag_n}, 4);
    check("tx_flag_oe_n", tx_flag_oe_n, 0);
    tx_reset_req_n = 1;
    wait_on(1);
    // Blocked cycle is the one after the clear pulse edge
    tick(1);
    tx_select_n = 0;
    tx_host_write = 1;
    tick(3);
    check("tx_fifo_push", tx_fifo_push, 0);
    check("tx_flags",
      {tx_empty_flag_n, tx_half_flag_n, tx_full_flag_n}, 3);
    check("tx_flag_oe_n", tx_flag_oe_n, 0);
    tx_select_n = 1;
    tick(1);
    tx_select_n = 0;
    tick(3);
    check("tx_fifo_push", tx_fifo_push, 1);
    {tx_select_n, tx_host_write, addr_match_n} = 3'h5;
    tick(2);
    check("tx_drain_en", tx_drain_en, 1);
    // Receive reset: forced empty until new data arrives
    rx_fifo_write = 1;
    tick(1);
    rx_fifo_write = 0;
    addr_match_n = 0;
    rx_reset_req_n = 0;
    tick(12);
    check("rx_empty_flag_n", rx_empty_flag_n, 0);
    check("rx_full_flag_n", rx_full_flag_n, 1);
    check("rx_clr_seen", rx_clr_seen, 0);
    rx_reset_req_n = 1;
    wait_on(2);
    tick(2);
    rx_fifo_write = 1;
    tick(1);
    rx_fifo_write = 0;
    tick(2);
    check("rx_empty_flag_n", rx_empty_flag_n, 1);
    stop_test();
  end
endmodule : tb_fifo_reset_and_addr_reg_access
`default_nettype wire
